// ==== rtl/result_bank_pkg.sv ====
// constants shared by the monitor result register bank
// Operation
// - voltage words: 14-bit code, top bits zero
// - 5.5V supply code scale 0.000458 V
// - aux pin 1 code scale 0.000305 V
// - aux pin 2 formatted like aux 1
// - thermistors 3..5 formatted like thermistor 1
// - thermistor code scale 0.000305 V, zero is 0V
// - fast current: signed 16-bit two's complement
// - slow current: same signed 16-bit format
// - 1.8V supply code scale 0.000305 V
package result_bank_pkg;

	// ==========================================
	// widths
	localparam int WORD_W = 16;
	localparam int VOLT_CODE_W = 14;
	localparam int CURR_CODE_W = 16;
	localparam int ADDR_W = 7;
	localparam int NUM_RESULTS = 9;
	localparam int IDX_W = 4;

	// ==========================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_THERM3 = 7'h41;
	localparam logic [ADDR_W-1:0] OFS_THERM4 = 7'h42;
	localparam logic [ADDR_W-1:0] OFS_THERM5 = 7'h43;
	localparam logic [ADDR_W-1:0] OFS_SUPPLY_5V5 = 7'h44;
	localparam logic [ADDR_W-1:0] OFS_AUX1 = 7'h45;
	localparam logic [ADDR_W-1:0] OFS_AUX2 = 7'h46;
	localparam logic [ADDR_W-1:0] OFS_FAST_CURR = 7'h47;
	localparam logic [ADDR_W-1:0] OFS_SLOW_CURR = 7'h48;
	localparam logic [ADDR_W-1:0] OFS_SUPPLY_1V8 = 7'h49;

	// ==========================================
	// slot indices inside the bank
	localparam logic [IDX_W-1:0] IDX_THERM3 = 4'h0;
	localparam logic [IDX_W-1:0] IDX_THERM4 = 4'h1;
	localparam logic [IDX_W-1:0] IDX_THERM5 = 4'h2;
	localparam logic [IDX_W-1:0] IDX_SUPPLY_5V5 = 4'h3;
	localparam logic [IDX_W-1:0] IDX_AUX1 = 4'h4;
	localparam logic [IDX_W-1:0] IDX_AUX2 = 4'h5;
	localparam logic [IDX_W-1:0] IDX_FAST_CURR = 4'h6;
	localparam logic [IDX_W-1:0] IDX_SLOW_CURR = 4'h7;
	localparam logic [IDX_W-1:0] IDX_SUPPLY_1V8 = 4'h8;

	// ==========================================
	// reset values
	localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] UNMAPPED_READ = 16'h0000;

endpackage

// ==== rtl/result_capture.sv ====
// one result word: captures a converter code and formats it into 16 bits
module result_capture
	import result_bank_pkg::*;
#(
	parameter int CODE_W = VOLT_CODE_W,
	parameter bit SIGNED_CODE = 1'b0
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [CODE_W-1:0] code_in,
	input wire logic code_valid_in,
	output logic [WORD_W-1:0] word_out
);

	// ==========================================
	// elaboration check
	generate
		if (CODE_W < 1 || CODE_W > WORD_W) begin : g_bad_width
			$error("result_capture: code width must be 1..16");
		end
		if (SIGNED_CODE && CODE_W != WORD_W) begin : g_bad_signed
			$error("result_capture: signed codes must fill the word");
		end
	endgenerate

	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] next_word;
	logic [WORD_W-1:0] formatted;

	// ==========================================
	// format: unsigned codes zero-padded, signed codes kept as is
	always_comb begin
		formatted = RESULT_RESET;
		formatted[CODE_W-1:0] = code_in;
		next_word = word;
		if (code_valid_in) begin
			next_word = formatted;
		end
	end

	// register the word, cleared by reset
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			word <= RESULT_RESET;
		end else begin
			word <= next_word;
		end
	end

	assign word_out = word;

endmodule

// ==== rtl/result_read_port.sv ====
// host read port: decodes the offset and returns the selected result word
module result_read_port
	import result_bank_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [WORD_W-1:0] words_in [NUM_RESULTS],
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	output logic [WORD_W-1:0] reg_rdata_out,
	output logic reg_ack_out,
	output logic reg_err_out
);

	logic [WORD_W-1:0] rdata;
	logic ack;
	logic err;
	logic [WORD_W-1:0] next_rdata;
	logic next_ack;
	logic next_err;
	logic hit;
	logic [IDX_W-1:0] idx;

	// ==========================================
	// offset decode: hit flag and slot index
	function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] addr);
		logic [IDX_W:0] res;
		res = '0;
		case (addr)
			OFS_THERM3: res = {1'b1, IDX_THERM3};
			OFS_THERM4: res = {1'b1, IDX_THERM4};
			OFS_THERM5: res = {1'b1, IDX_THERM5};
			OFS_SUPPLY_5V5: res = {1'b1, IDX_SUPPLY_5V5};
			OFS_AUX1: res = {1'b1, IDX_AUX1};
			OFS_AUX2: res = {1'b1, IDX_AUX2};
			OFS_FAST_CURR: res = {1'b1, IDX_FAST_CURR};
			OFS_SLOW_CURR: res = {1'b1, IDX_SLOW_CURR};
			OFS_SUPPLY_1V8: res = {1'b1, IDX_SUPPLY_1V8};
			default: res = '0;
		endcase
		return res;
	endfunction

	// ==========================================
	// answer: one ack for each cycle a request is held, writes always refused
	always_comb begin
		{hit, idx} = decode(reg_addr_in);
		next_rdata = rdata;
		next_ack = 1'b0;
		next_err = 1'b0;
		if (reg_wr_in) begin
			next_ack = 1'b1;
			next_err = 1'b1;
		end else if (reg_rd_in) begin
			next_ack = 1'b1;
			next_err = !hit;
			next_rdata = hit ? words_in[idx] : UNMAPPED_READ;
		end
	end

	// register the answer
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata <= RESULT_RESET;
			ack <= 1'b0;
			err <= 1'b0;
		end else begin
			rdata <= next_rdata;
			ack <= next_ack;
			err <= next_err;
		end
	end

	assign reg_rdata_out = rdata;
	assign reg_ack_out = ack;
	assign reg_err_out = err;

endmodule

// ==== rtl/monitor_adc_result_bank.sv ====
// read-only bank of thermistor, aux pin, supply and current results
module monitor_adc_result_bank
	import result_bank_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [VOLT_CODE_W-1:0] therm3_code_in,
	input wire logic therm3_valid_in,
	input wire logic [VOLT_CODE_W-1:0] therm4_code_in,
	input wire logic therm4_valid_in,
	input wire logic [VOLT_CODE_W-1:0] therm5_code_in,
	input wire logic therm5_valid_in,
	input wire logic [VOLT_CODE_W-1:0] supply_5v5_code_in,
	input wire logic supply_5v5_valid_in,
	input wire logic [VOLT_CODE_W-1:0] aux1_code_in,
	input wire logic aux1_valid_in,
	input wire logic [VOLT_CODE_W-1:0] aux2_code_in,
	input wire logic aux2_valid_in,
	input wire logic [CURR_CODE_W-1:0] fast_curr_code_in,
	input wire logic fast_curr_valid_in,
	input wire logic [CURR_CODE_W-1:0] slow_curr_code_in,
	input wire logic slow_curr_valid_in,
	input wire logic [VOLT_CODE_W-1:0] supply_1v8_code_in,
	input wire logic supply_1v8_valid_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [WORD_W-1:0] reg_wdata_in,
	output logic [WORD_W-1:0] reg_rdata_out,
	output logic reg_ack_out,
	output logic reg_err_out
);

	logic [CURR_CODE_W-1:0] codes [NUM_RESULTS];
	logic valids [NUM_RESULTS];
	logic [WORD_W-1:0] words [NUM_RESULTS];

	// ==========================================
	// gather converter inputs by slot; voltage codes are unsigned
	// 14-bit values, so they are zero-padded to the common width
	assign codes[IDX_THERM3] = {2'b00, therm3_code_in};
	assign codes[IDX_THERM4] = {2'b00, therm4_code_in};
	assign codes[IDX_THERM5] = {2'b00, therm5_code_in};
	assign codes[IDX_SUPPLY_5V5] = {2'b00, supply_5v5_code_in};
	assign codes[IDX_AUX1] = {2'b00, aux1_code_in};
	assign codes[IDX_AUX2] = {2'b00, aux2_code_in};
	assign codes[IDX_FAST_CURR] = fast_curr_code_in;
	assign codes[IDX_SLOW_CURR] = slow_curr_code_in;
	assign codes[IDX_SUPPLY_1V8] = {2'b00, supply_1v8_code_in};

	// update strobes by slot
	assign valids[IDX_THERM3] = therm3_valid_in;
	assign valids[IDX_THERM4] = therm4_valid_in;
	assign valids[IDX_THERM5] = therm5_valid_in;
	assign valids[IDX_SUPPLY_5V5] = supply_5v5_valid_in;
	assign valids[IDX_AUX1] = aux1_valid_in;
	assign valids[IDX_AUX2] = aux2_valid_in;
	assign valids[IDX_FAST_CURR] = fast_curr_valid_in;
	assign valids[IDX_SLOW_CURR] = slow_curr_valid_in;
	assign valids[IDX_SUPPLY_1V8] = supply_1v8_valid_in;

	// ==========================================
	// one capture register per slot; current slots keep all 16 bits
	// signed, voltage slots keep only the low 14 bits
	generate
		for (genvar i = 0; i < NUM_RESULTS; i++) begin : g_slot
			if (i == IDX_FAST_CURR || i == IDX_SLOW_CURR) begin : g_curr
				result_capture #(
					.CODE_W(CURR_CODE_W),
					.SIGNED_CODE(1'b1)
				) u_capture (
					.sys_clk_in(sys_clk_in),
					.resetn_in(resetn_in),
					.code_in(codes[i]),
					.code_valid_in(valids[i]),
					.word_out(words[i])
				);
			end else begin : g_volt
				result_capture #(
					.CODE_W(VOLT_CODE_W),
					.SIGNED_CODE(1'b0)
				) u_capture (
					.sys_clk_in(sys_clk_in),
					.resetn_in(resetn_in),
					.code_in(codes[i][VOLT_CODE_W-1:0]),
					.code_valid_in(valids[i]),
					.word_out(words[i])
				);
			end
		end
	endgenerate

	// ==========================================
	// host access; write data is never stored
	result_read_port u_read_port (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.words_in(words),
		.reg_addr_in(reg_addr_in),
		.reg_rd_in(reg_rd_in),
		.reg_wr_in(reg_wr_in),
		.reg_rdata_out(reg_rdata_out),
		.reg_ack_out(reg_ack_out),
		.reg_err_out(reg_err_out)
	);

endmodule

// ==== bench/result_bank_properties.sv ====
// assertions on the result bank register port
module result_bank_properties
	import result_bank_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [CURR_CODE_W-1:0] fast_curr_code_in,
	input wire logic fast_curr_valid_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [WORD_W-1:0] reg_rdata_out,
	input wire logic reg_ack_out,
	input wire logic reg_err_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	// read decode
	logic rd, mapped, volt;
	assign rd = reg_rd_in && !reg_wr_in;
	assign mapped = reg_addr_in >= OFS_THERM3 && reg_addr_in <= OFS_SUPPLY_1V8;
	assign volt = mapped && reg_addr_in != OFS_FAST_CURR && reg_addr_in != OFS_SLOW_CURR;
	sequence fast_cap_s;
		fast_curr_valid_in ##1 !fast_curr_valid_in ##1 (rd && reg_addr_in == OFS_FAST_CURR && !fast_curr_valid_in);
	endsequence
	ack_timing_a: assert property ((reg_rd_in || reg_wr_in) |=> reg_ack_out) else $error("no ack");
	ack_idle_a: assert property (!(reg_rd_in || reg_wr_in) |=> !reg_ack_out && !reg_err_out) else $error("stray");
	write_refused_a: assert property (reg_wr_in |=> reg_err_out) else $error("write taken");
	rdata_hold_a: assert property (!rd |=> $stable(reg_rdata_out)) else $error("rdata moved");
	volt_top_zero_a: assert property (rd && volt |=> reg_rdata_out[15:14] == 2'b00) else $error("top bits");
	mapped_ok_a: assert property (rd && mapped |=> !reg_err_out) else $error("mapped err");
	unmapped_zero_a: assert property (rd && !mapped |=> reg_err_out && reg_rdata_out == 16'h0000) else $error("unmapped");
	fast_word_a: assert property (fast_cap_s |=> reg_rdata_out == $past(fast_curr_code_in, 3)) else $error("fast");
endmodule
bind monitor_adc_result_bank result_bank_properties props (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
	.fast_curr_code_in(fast_curr_code_in), .fast_curr_valid_in(fast_curr_valid_in), .reg_addr_in(reg_addr_in),
	.reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
	.reg_err_out(reg_err_out));

// ==== bench/host_model.sv ====
// host model issuing single register requests
module host_model
	import result_bank_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic [WORD_W-1:0] reg_rdata_in,
	input wire logic reg_ack_in,
	input wire logic reg_err_in,
	output logic [ADDR_W-1:0] reg_addr_out = 7'h00,
	output logic reg_rd_out = 1'b0,
	output logic reg_wr_out = 1'b0,
	output logic [WORD_W-1:0] reg_wdata_out = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	// request held up to the ack edge, answer taken on that edge; op bit 0 reads, bit 1 writes
	// the held request is taken once more at the ack edge: a repeat read or a refused write, harmless
	task automatic access(input logic [ADDR_W-1:0] a, input logic [1:0] op, output logic [WORD_W-1:0] d,
		output logic e, output logic k);
		@(posedge sys_clk_in);
		#1;
		reg_addr_out = a;
		reg_rd_out = op[0];
		reg_wr_out = op[1];
		reg_wdata_out = ~reg_wdata_out; // junk data, changes each request
		@(posedge sys_clk_in); // request taken here
		@(posedge sys_clk_in); // ack sampled high here
		d = reg_rdata_in;
		e = reg_err_in;
		k = reg_ack_in;
		#1;
		reg_rd_out = 1'b0;
		reg_wr_out = 1'b0;
		reg_addr_out = ~a; // released address does not linger
	endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the result register bank
module testbench
	import result_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in, resetn_in, rd, wr, ack, err, e, k;
	logic [ADDR_W-1:0] addr;
	logic [WORD_W-1:0] wdata, rdata, got;
	logic [WORD_W-1:0] c [9];
	logic v [9];
	int err_total, check_count;
	logic [WORD_W-1:0] cur [3] = '{16'h8000, 16'hFFFF, 16'h7FFF};
	logic [ADDR_W-1:0] ofs [9] = '{OFS_THERM3, OFS_THERM4, OFS_THERM5, OFS_SUPPLY_5V5, OFS_AUX1, OFS_AUX2,
		OFS_FAST_CURR, OFS_SLOW_CURR, OFS_SUPPLY_1V8};
	monitor_adc_result_bank dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.therm3_code_in(c[0][13:0]), .therm3_valid_in(v[0]), .therm4_code_in(c[1][13:0]), .therm4_valid_in(v[1]),
		.therm5_code_in(c[2][13:0]), .therm5_valid_in(v[2]), .supply_5v5_code_in(c[3][13:0]),
		.supply_5v5_valid_in(v[3]), .aux1_code_in(c[4][13:0]), .aux1_valid_in(v[4]), .aux2_code_in(c[5][13:0]),
		.aux2_valid_in(v[5]), .fast_curr_code_in(c[6]), .fast_curr_valid_in(v[6]), .slow_curr_code_in(c[7]),
		.slow_curr_valid_in(v[7]), .supply_1v8_code_in(c[8][13:0]), .supply_1v8_valid_in(v[8]),
		.reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_ack_out(ack), .reg_err_out(err));
	host_model host (.sys_clk_in(sys_clk_in), .reg_rdata_in(rdata), .reg_ack_in(ack), .reg_err_in(err),
		.reg_addr_out(addr), .reg_rd_out(rd), .reg_wr_out(wr), .reg_wdata_out(wdata));
	// compare and report
	task automatic chk(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] x);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// read and check word, ack and error flag
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] x, input logic xe);
		host.access(a, 2'b01, got, e, k);
		chk(got, x);
		chk({14'h0000, k, e}, {14'h0000, 1'b1, xe});
	endtask
	// one capture pulse on a converter slot
	task automatic cap(input int i, input logic [WORD_W-1:0] x);
		@(posedge sys_clk_in);
		#1;
		c[i] = x;
		v[i] = 1'b1;
		@(posedge sys_clk_in);
		#1;
		v[i] = 1'b0;
		c[i] = ~x;
	endtask
	task automatic stop_test;
		$display("mismatches %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// clock
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	// watchdog
	initial begin
		repeat (3000) @(posedge sys_clk_in);
		err_total++;
		stop_test();
	end
	// tests
	initial begin
		resetn_in = 1'b0;
		for (int i = 0; i < 9; i++) begin
			c[i] = 16'h0000;
			v[i] = 1'b0;
		end
		repeat (2) @(posedge sys_clk_in);
		#1;
		resetn_in = 1'b1;
		for (int i = 0; i < 9; i++) rdchk(ofs[i], 16'h0000, 1'b0);
		for (int i = 0; i < 9; i++) if (i != 6 && i != 7) begin
			cap(i, 16'hFFFF);
			rdchk(ofs[i], 16'h3FFF, 1'b0);
			cap(i, 16'h2001);
			rdchk(ofs[i], 16'h2001, 1'b0);
		end
		for (int j = 0; j < 3; j++) begin
			cap(7, cur[j]);
			cap(6, ~cur[j]);
			rdchk(OFS_FAST_CURR, ~cur[j], 1'b0);
			rdchk(OFS_SLOW_CURR, cur[j], 1'b0);
		end
		host.access(OFS_FAST_CURR, 2'b10, got, e, k);
		chk(got, cur[2]);
		chk({14'h0000, k, e}, 16'h0003);
		// read and write together: the write wins and is refused, read data stays
		host.access(OFS_FAST_CURR, 2'b11, got, e, k);
		chk(got, cur[2]);
		chk({14'h0000, k, e}, 16'h0003);
		rdchk(OFS_FAST_CURR, ~cur[2], 1'b0);
		rdchk(7'h40, 16'h0000, 1'b1);
		rdchk(7'h4A, 16'h0000, 1'b1);
		@(posedge sys_clk_in);
		#1;
		resetn_in = 1'b0;
		@(posedge sys_clk_in);
		#1;
		resetn_in = 1'b1;
		rdchk(OFS_FAST_CURR, 16'h0000, 1'b0);
		stop_test();
	end
endmodule
